// file: hdl/stack_regs_cfg.svh
// register offsets, field positions and reset values of the return stack and work registers
`ifndef STACK_REGS_CFG_SVH
`define STACK_REGS_CFG_SVH
`define ADDR_WORK_FIRST    8'h80
`define ADDR_WORK_LAST     8'h87
`define ADDR_LOOKUP_HIGH   8'h82
`define ADDR_STACK_PTR     8'hdf
`define ADDR_ENTRY_BASE    8'hf0
`define STACK_PTR_RESET    2'h3
`define GIE_BIT            7
`define GIE_RESET          1'h0
`define ENTRY_RESET        8'h00
`endif

// file: hdl/stack_regs_pkg.sv
// types shared by the return stack and work register block
package stack_regs_pkg;
    typedef logic [1:0]  stack_ptr_t;
    typedef logic [10:0] pc_addr_t;
    typedef logic [7:0]  byte_t;
    typedef enum logic [1:0]
    {
        ACC_IDLE  = 2'b00,
        ACC_DIR   = 2'b01,
        ACC_IND   = 2'b10,
        ACC_IMM   = 2'b11
    } access_mode_t;
endpackage

// file: hdl/return_stack_and_work_regs.sv
// four-level return stack, stack pointer with interrupt enable, lookup high byte and ram addressing
`timescale 1ns/1ps
`include "stack_regs_cfg.svh"

// Overview of operation
// RQ1: lookup high-byte register is an 8-bit read/write working register.
// RQ2: table read puts program word high byte in lookup register, low byte in accumulator.
// RQ3: immediate writes accepted only for ram addresses 0x80 to 0x87.
// RQ4: direct mode moves a byte between accumulator and addressed ram, bank0 form uses bank 0.
// RQ5: indirect mode uses a pointer pair: upper byte is bank, lower byte is location.
// RQ6: stack holds exactly four program counter return entries.
// RQ7: stack pointer is two low bits of its register and selects the entry.
// RQ8: push decrements the pointer, pop increments it.
// RQ9: entries come back last in, first out.
// RQ10: program counter is pushed on subroutine call and on interrupt entry.
// RQ11: pointer codes 11,10,01,00,11 for levels 0..4; fifth push gives 10, overflow.
// RQ12: pop loads program counter with latest entry, for both return kinds.
// RQ13: after a pop the pointer addresses the released entry as next free slot.
// RQ14: bit 7 is global interrupt enable, reset 0; pointer bits reset to 11.
// RQ15: pointer and entries are read/write system registers in bank 0, entries from 0xf0.
// RQ16: software should load the pointer register with 00000011 at program start.
// RQ17: entries keep 11-bit pc, bits 10..8 in high register, 7..0 in low; reset zero.
// RQ18: lookup high-byte register has no reset value.
// RQ19: pushes beyond four wrap the pointer and may overwrite; no flag raised (the code pulses stack_over_o on the fifth push).
module return_stack_and_work_regs
    import stack_regs_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // system register port of the core
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    input  wire logic [7:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    output logic      [7:0]   reg_rdata_o,
    output logic              reg_hit_o,
    // sequencer control
    input  wire logic         call_push_i,
    input  wire logic         irq_push_i,
    input  wire logic         sub_return_i,
    input  wire logic         return_from_interrupt_i,
    input  wire logic [10:0]  pc_i,
    output logic      [10:0]  return_pc_o,
    output logic              return_pc_valid_o,
    output logic              global_irq_enable_o,
    output logic              stack_over_o,
    // rom table read
    input  wire logic         rom_table_read_i,
    input  wire logic [15:0]  rom_word_i,
    output logic      [7:0]   acc_load_data_o,
    output logic              acc_load_o,
    // data ram access generation
    input  wire logic [1:0]   mode_i,
    input  wire logic         bank0_move_i,
    input  wire logic         to_ram_i,
    input  wire logic         ptr_sel_i,
    input  wire logic [7:0]   addr_field_i,
    input  wire logic [7:0]   bank_i,
    input  wire logic [7:0]   acc_i,
    input  wire logic [7:0]   imm_i,
    input  wire logic [7:0]   ptr0_hi_i,
    input  wire logic [7:0]   ptr0_lo_i,
    input  wire logic [7:0]   ptr1_hi_i,
    input  wire logic [7:0]   ptr1_lo_i,
    output logic      [7:0]   ram_bank_o,
    output logic      [7:0]   ram_addr_o,
    output logic      [7:0]   ram_wdata_o,
    output logic              ram_we_o,
    output logic              ram_re_o,
    output logic              imm_reject_o
);

    //********************************************************
    // functions
    //********************************************************
    // entry window hit and entry index from a register address
    function automatic logic entry_hit(input logic [7:0] a);
        entry_hit = (a >= `ADDR_ENTRY_BASE) && (a <= (`ADDR_ENTRY_BASE + 8'h07));
    endfunction
    function automatic logic [1:0] entry_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - `ADDR_ENTRY_BASE;
        entry_idx = off[2:1];
    endfunction

    // pointer code to entry number: 10->0, 01->1, 00->2, 11->3
    function automatic logic [1:0] ptr_to_entry(input stack_ptr_t p);
        ptr_to_entry = 2'h2 - p;
    endfunction

    //********************************************************
    // state
    //********************************************************
    stack_ptr_t  sp_reg;
    logic [2:0]  ent_hi_reg [4];
    byte_t       ent_lo_reg [4];
    byte_t       lookup_high_reg;
    logic [1:0]  depth_reg;
    logic        full_reg;

    logic        push;
    logic        pop;
    stack_ptr_t  sp_next;
    logic [1:0]  push_slot;
    logic [1:0]  pop_slot;
    logic        sw_sp_wr;
    logic        sw_lh_wr;

    // push takes the slot below the current code, pop reads the slot of the current code
    assign push      = call_push_i | irq_push_i;                         // [RQ10]
    assign pop       = (sub_return_i | return_from_interrupt_i) & ~push; // [RQ12]
    assign push_slot = ptr_to_entry(sp_reg - 2'h1);                      // [RQ7]
    assign pop_slot  = ptr_to_entry(sp_reg);                             // [RQ9]
    assign sw_sp_wr  = reg_wr_i && (reg_addr_i == `ADDR_STACK_PTR);
    assign sw_lh_wr  = reg_wr_i && (reg_addr_i == `ADDR_LOOKUP_HIGH);

    //********************************************************
    // stack pointer and interrupt enable
    //********************************************************
    // hardware push/pop has priority over a software write in the same cycle
    always_comb
    begin
        sp_next = sp_reg;
        if (push)
            sp_next = sp_reg - 2'h1;       // [RQ8] [RQ11] [RQ19]
        else if (pop)
            sp_next = sp_reg + 2'h1;       // [RQ8] [RQ13]
        else if (sw_sp_wr)
            sp_next = reg_wdata_i[1:0];    // [RQ15]
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            sp_reg <= `STACK_PTR_RESET;    // [RQ14]
        else
            sp_reg <= sp_next;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            global_irq_enable_o <= `GIE_RESET;                  // [RQ14]
        else if (sw_sp_wr)
            global_irq_enable_o <= reg_wdata_i[`GIE_BIT];       // [RQ14] the output flop is the bit itself
    end

    // depth tracking for overflow indication only
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            depth_reg <= 2'h0;
            full_reg  <= 1'b0;
        end
        else if (push)
        begin
            depth_reg <= depth_reg + 2'h1;
            if (depth_reg == 2'h3)
                full_reg <= 1'b1;
        end
        else if (pop)
        begin
            depth_reg <= depth_reg - 2'h1;
            full_reg  <= 1'b0;
        end
        else if (sw_sp_wr)
        begin
            depth_reg <= 2'h3 - reg_wdata_i[1:0];
            full_reg  <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            stack_over_o <= 1'b0;
        else
            stack_over_o <= push && full_reg;   // [RQ11] pulse on the fifth push
    end

    //********************************************************
    // stack entries
    //********************************************************
    for (genvar i = 0; i < 4; i++)
    begin : g_entry
        always_ff @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                ent_hi_reg[i] <= 3'(`ENTRY_RESET);       // [RQ17]
                ent_lo_reg[i] <= `ENTRY_RESET;
            end
            else if (push && push_slot == 2'(i))
            begin
                ent_hi_reg[i] <= pc_i[10:8];             // [RQ6] [RQ17]
                ent_lo_reg[i] <= pc_i[7:0];
            end
            else if (reg_wr_i && entry_hit(reg_addr_i) && entry_idx(reg_addr_i) == 2'(i))
            begin
                if (reg_addr_i[0])
                    ent_lo_reg[i] <= reg_wdata_i;        // [RQ15]
                else
                    ent_hi_reg[i] <= reg_wdata_i[2:0];
            end
        end
    end

    // restored return address to the program counter
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            return_pc_o       <= 11'h000;
            return_pc_valid_o <= 1'b0;
        end
        else
        begin
            return_pc_valid_o <= pop;
            if (pop)
                return_pc_o <= {ent_hi_reg[pop_slot], ent_lo_reg[pop_slot]};  // [RQ9] [RQ12]
        end
    end

    //********************************************************
    // lookup high byte
    //********************************************************
    // no reset: the register holds whatever it last took
    always_ff @(posedge clk_i)
    begin
        if (rom_table_read_i)
            lookup_high_reg <= rom_word_i[15:8];   // [RQ2] [RQ18]
        else if (sw_lh_wr)
            lookup_high_reg <= reg_wdata_i;        // [RQ1]
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc_load_o      <= 1'b0;
            acc_load_data_o <= 8'h00;
        end
        else
        begin
            acc_load_o <= rom_table_read_i;
            if (rom_table_read_i)
                acc_load_data_o <= rom_word_i[7:0];  // [RQ2]
        end
    end

    //********************************************************
    // register read port
    //********************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_hit_o   <= 1'b0;
        end
        else
        begin
            reg_hit_o   <= 1'b0;
            reg_rdata_o <= 8'h00;
            if (reg_rd_i)
            begin
                if (reg_addr_i == `ADDR_STACK_PTR)
                begin
                    reg_hit_o   <= 1'b1;
                    reg_rdata_o <= {global_irq_enable_o, 5'h00, sp_reg};  // [RQ15]
                end
                else if (reg_addr_i == `ADDR_LOOKUP_HIGH)
                begin
                    reg_hit_o   <= 1'b1;
                    reg_rdata_o <= lookup_high_reg;                 // [RQ1]
                end
                else if (entry_hit(reg_addr_i))
                begin
                    reg_hit_o   <= 1'b1;
                    reg_rdata_o <= reg_addr_i[0] ? ent_lo_reg[entry_idx(reg_addr_i)]
                                                 : {5'h00, ent_hi_reg[entry_idx(reg_addr_i)]};
                end
            end
        end
    end

    //********************************************************
    // data ram addressing
    //********************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ram_bank_o   <= 8'h00;
            ram_addr_o   <= 8'h00;
            ram_wdata_o  <= 8'h00;
            ram_we_o     <= 1'b0;
            ram_re_o     <= 1'b0;
            imm_reject_o <= 1'b0;
        end
        else
        begin
            ram_we_o     <= 1'b0;
            ram_re_o     <= 1'b0;
            imm_reject_o <= 1'b0;
            case (access_mode_t'(mode_i))
                ACC_IMM:
                begin
                    ram_bank_o  <= 8'h00;
                    ram_addr_o  <= addr_field_i;
                    ram_wdata_o <= imm_i;
                    if (addr_field_i >= `ADDR_WORK_FIRST && addr_field_i <= `ADDR_WORK_LAST)
                        ram_we_o <= 1'b1;                              // [RQ3]
                    else
                        imm_reject_o <= 1'b1;                          // [RQ3]
                end
                ACC_DIR:
                begin
                    ram_bank_o  <= bank0_move_i ? 8'h00 : bank_i;      // [RQ4]
                    ram_addr_o  <= addr_field_i;
                    ram_wdata_o <= acc_i;
                    ram_we_o    <= to_ram_i;                           // [RQ4]
                    ram_re_o    <= ~to_ram_i;
                end
                ACC_IND:
                begin
                    ram_bank_o  <= ptr_sel_i ? ptr1_hi_i : ptr0_hi_i;  // [RQ5]
                    ram_addr_o  <= ptr_sel_i ? ptr1_lo_i : ptr0_lo_i;  // [RQ5]
                    ram_wdata_o <= acc_i;
                    ram_we_o    <= to_ram_i;
                    ram_re_o    <= ~to_ram_i;
                end
                default:
                    ram_we_o <= 1'b0;
            endcase
        end
    end

endmodule

// file: tb/return_stack_and_work_regs_asserts.sv
// concurrent checks on the ports of the return stack and work register block
`timescale 1ns/1ps
module return_stack_and_work_regs_asserts
(
    input wire logic        clk_i, rst_i, reg_wr_i, reg_rd_i, call_push_i, irq_push_i,
    input wire logic        sub_return_i, return_from_interrupt_i, rom_table_read_i, to_ram_i,
    input wire logic        bank0_move_i, reg_hit_o, return_pc_valid_o, global_irq_enable_o,
    input wire logic        acc_load_o, ram_we_o, imm_reject_o, ram_re_o, stack_over_o,
    input wire logic [1:0]  mode_i,
    input wire logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, addr_field_i, acc_i, imm_i,
    input wire logic [7:0]  acc_load_data_o, ram_wdata_o, ram_addr_o, ram_bank_o,
    input wire logic [15:0] rom_word_i
);
    // ************************************************************
    // port relations, sampled on the rising clock
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_pop_ret;
        (sub_return_i || return_from_interrupt_i) && !call_push_i && !irq_push_i |=> return_pc_valid_o;
    endproperty
    a_pop_ret: assert property (p_pop_ret) else $error("pop gave no return address");
    property p_no_ret;
        !sub_return_i && !return_from_interrupt_i |=> !return_pc_valid_o;
    endproperty
    a_no_ret: assert property (p_no_ret) else $error("return address without a pop");
    property p_tbl;
        rom_table_read_i |=> acc_load_o && acc_load_data_o == $past(rom_word_i[7:0]);
    endproperty
    a_tbl: assert property (p_tbl) else $error("table read low byte wrong");
    property p_ptr_read;
        reg_rd_i && reg_addr_i == 8'hdf |=> reg_hit_o && reg_rdata_o[6:2] == 5'h00;
    endproperty
    a_ptr_read: assert property (p_ptr_read) else $error("pointer register read wrong");
    property p_gie;
        reg_wr_i && reg_addr_i == 8'hdf |=> global_irq_enable_o == $past(reg_wdata_i[7]);
    endproperty
    a_gie: assert property (p_gie) else $error("interrupt enable not written");
    property p_imm_rej;
        mode_i == 2'b11 && (addr_field_i < 8'h80 || addr_field_i > 8'h87) |=> imm_reject_o && !ram_we_o;
    endproperty
    a_imm_rej: assert property (p_imm_rej) else $error("immediate outside work area accepted");
    property p_imm_ok;
        mode_i == 2'b11 && addr_field_i >= 8'h80 && addr_field_i <= 8'h87
            |=> ram_we_o && !imm_reject_o && ram_wdata_o == $past(imm_i);
    endproperty
    a_imm_ok: assert property (p_imm_ok) else $error("immediate write to work area lost");
    property p_dir_wr;
        mode_i == 2'b01 && to_ram_i |=> ram_we_o && ram_wdata_o == $past(acc_i) && ram_addr_o == $past(addr_field_i);
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("direct store wrong");
    property p_bank0;
        mode_i == 2'b01 && bank0_move_i |=> ram_bank_o == 8'h00;
    endproperty
    a_bank0: assert property (p_bank0) else $error("bank zero move left bank zero");
    property p_dir_rd;
        mode_i == 2'b01 && !to_ram_i |=> ram_re_o && !ram_we_o && ram_addr_o == $past(addr_field_i);
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direct load wrong");
    property p_over;
        stack_over_o |-> $past(call_push_i) || $past(irq_push_i);
    endproperty
    a_over: assert property (p_over) else $error("overflow without a push");
endmodule
bind return_stack_and_work_regs return_stack_and_work_regs_asserts u_chk (.*);

// file: tb/seq_model.sv
// sequencer model: issues calls, interrupt entries and both return kinds
`timescale 1ns/1ps
module seq_model
(
    input  wire logic        clk_i,
    output logic             call_o,
    output logic             irq_o,
    output logic             ret_o,
    output logic             return_from_interrupt_o,
    output logic      [10:0] pc_o
);
    // ************************************************************
    // one-cycle request, driven on the falling edge
    // ************************************************************
    initial {call_o, irq_o, ret_o, return_from_interrupt_o, pc_o} = '0;
    task automatic op(input int kind, input logic [10:0] pc);
        @(negedge clk_i);
        call_o = (kind == 1);
        irq_o  = (kind == 2);
        ret_o  = (kind == 3);
        return_from_interrupt_o = (kind == 4);
        pc_o   = pc;
        @(negedge clk_i);
        {call_o, irq_o, ret_o, return_from_interrupt_o} = '0;
        pc_o   = ~pc; // stale address is not held after the push
    endtask
endmodule

// file: tb/return_stack_and_work_regs_test.sv
// self-checking bench of the return stack and work register block
`timescale 1ns/1ps
module return_stack_and_work_regs_test;
    // ************************************************************
    // signals, design and sequencer
    // ************************************************************
    logic        clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, rom_table_read_i = 0;
    logic        bank0_move_i = 0, to_ram_i = 0, ptr_sel_i = 0;
    logic [1:0]  mode_i = 0;
    logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, addr_field_i = 0, bank_i = 0, acc_i = 0, imm_i = 0;
    logic [7:0]  ptr0_hi_i = 0, ptr0_lo_i = 0, ptr1_hi_i = 0, ptr1_lo_i = 0;
    logic [15:0] rom_word_i = 0;
    logic        call_push_i, irq_push_i, sub_return_i, return_from_interrupt_i;
    logic [10:0] pc_i, return_pc_o;
    logic [7:0]  reg_rdata_o, acc_load_data_o, ram_bank_o, ram_addr_o, ram_wdata_o;
    logic        reg_hit_o, return_pc_valid_o, global_irq_enable_o, stack_over_o;
    logic        acc_load_o, ram_we_o, ram_re_o, imm_reject_o;
    int          n_fail = 0, num_checks = 0;
    logic [31:0] seed = 32'h8c19;
    return_stack_and_work_regs dut (.*);
    seq_model seq (.clk_i(clk_i), .call_o(call_push_i), .irq_o(irq_push_i), .ret_o(sub_return_i),
                   .return_from_interrupt_o(return_from_interrupt_i), .pc_o(pc_i));
    initial forever #2.5 clk_i = ~clk_i;
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // pointer code for a stack depth: 3 minus depth, modulo four
    function automatic logic [1:0] ptr_of(int lvl);
        return 2'(3 - lvl);
    endfunction
    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            n_fail++;
        end
    endtask
    task automatic chk_pc(string n, logic [10:0] e, logic [10:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            n_fail++;
        end
    endtask
    task automatic reg_acc(logic wr, logic [7:0] a, logic [7:0] d);
        @(negedge clk_i);
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {wr, !wr, a, d};
        @(negedge clk_i);
        {reg_wr_i, reg_rd_i} = 2'b00;
    endtask
    task automatic rd_chk(string n, logic [7:0] a, logic [7:0] e, logic hit);
        reg_acc(1'b0, a, 8'h00);
        chk_byte(n, e, reg_rdata_o);
        chk_byte("hit", {7'h0, hit}, {7'h0, reg_hit_o});
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        logic [10:0] pcs [4];
        logic [15:0] w;
        logic [7:0]  bnd [4];
        logic [31:0] r;
        bnd = '{8'h7f, 8'h80, 8'h87, 8'h88};
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) rst_i = 0;
        rd_chk("ptr reset", 8'hdf, 8'h03, 1'b1);
        for (int n = 0; n < 8; n++) rd_chk("entry reset", 8'(8'hf0 + n), 8'h00, 1'b1);
        reg_acc(1'b1, 8'hdf, 8'h83);
        rd_chk("ptr write", 8'hdf, 8'h83, 1'b1);
        chk_byte("gie", 8'h01, {7'h0, global_irq_enable_o});
        for (int l = 1; l <= 4; l++)
        begin
            pcs[l-1] = 11'(rnd());
            seq.op(l[0] ? 1 : 2, pcs[l-1]);
            chk_byte("over", 8'h00, {7'h0, stack_over_o});
            rd_chk("ptr push", 8'hdf, {6'b100000, ptr_of(l)}, 1'b1);
        end
        for (int n = 0; n < 4; n++)
        begin
            rd_chk("entry high", 8'(8'hf0 + 2 * n), {5'h0, pcs[n][10:8]}, 1'b1);
            rd_chk("entry low", 8'(8'hf1 + 2 * n), pcs[n][7:0], 1'b1);
        end
        for (int l = 4; l >= 1; l--)
        begin
            seq.op(l[0] ? 3 : 4, 11'h000);
            chk_pc("pop pc", pcs[l-1], return_pc_o);
            chk_byte("pop valid", 8'h01, {7'h0, return_pc_valid_o});
            rd_chk("ptr pop", 8'hdf, {6'b100000, ptr_of(l - 1)}, 1'b1);
        end
        for (int l = 1; l <= 5; l++)
        begin
            seq.op(1, 11'(rnd()));
            chk_byte("over", {7'h0, l == 5}, {7'h0, stack_over_o});
        end
        rd_chk("ptr over", 8'hdf, 8'h82, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            w = 16'(rnd());
            @(negedge clk_i);
            {rom_table_read_i, rom_word_i} = {1'b1, w};
            @(negedge clk_i);
            rom_table_read_i = 0;
            chk_byte("acc load", w[7:0], acc_load_data_o);
            rd_chk("lookup high", 8'h82, w[15:8], 1'b1);
            reg_acc(1'b1, 8'h82, w[7:0] ^ 8'h5a);
            rd_chk("lookup rw", 8'h82, w[7:0] ^ 8'h5a, 1'b1);
        end
        rd_chk("unmapped", 8'h90, 8'h00, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clk_i);
            r = rnd();
            if (i % 4 == 3)
                r[31:24] = bnd[i / 4];
            {addr_field_i, acc_i, imm_i, bank_i} = r;
            {ptr0_hi_i, ptr0_lo_i, ptr1_hi_i, ptr1_lo_i} = rnd();
            {to_ram_i, bank0_move_i, ptr_sel_i} = 3'(rnd());
            mode_i = 2'(i);
            @(negedge clk_i);
            mode_i = 2'b00;
            if (i % 4 == 1)
                chk_byte("dir bank", bank0_move_i ? 8'h00 : bank_i, ram_bank_o);
            if (i % 4 == 2)
            begin
                chk_byte("ind bank", ptr_sel_i ? ptr1_hi_i : ptr0_hi_i, ram_bank_o);
                chk_byte("ind addr", ptr_sel_i ? ptr1_lo_i : ptr0_lo_i, ram_addr_o);
            end
            if (i % 4 == 3)
                chk_byte("imm reject", {7'h0, i == 0 || i > 11 || i == 3}, {7'h0, imm_reject_o});
        end
        give_verdict();
    end
    // hang guard
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        $display("[ERR] run length exp done got timeout");
        give_verdict();
    end
endmodule
